/* design/clock_gate_consts.vh */
// Constants for the clock output gating and selection block.
// Assumes a 25 MHz ref_clk and a zero-wait AHB-Lite slave at byte addresses.
`ifndef CLOCK_GATE_CONSTS_VH
`define CLOCK_GATE_CONSTS_VH

// Register byte offsets.
`define OFS_STATUS 12'h000
`define OFS_IRQ_STATUS 12'h004
`define OFS_IRQ_MASK 12'h008
`define OFS_BANK_BASE 12'h100
`define OFS_DIV_BASE 12'h200

// Bank configuration word fields.
`define BCFG_DIV_LSB 0
`define BCFG_DRV_LSB 3
`define BCFG_GATE_BIT 6
`define BCFG_OEA_LSB 8
`define BCFG_OEB_LSB 10

// Enable source encodings.
`define OE_ALWAYS_ON 2'h0
`define OE_ALWAYS_OFF 2'h1
`define OE_PIN_X 2'h2
`define OE_PIN_Y 2'h3

// Interrupt status bits.
`define IRQ_LOCK_GAINED 0
`define IRQ_LOCK_LOST 1
`define IRQ_PROFILE_CHG 2

// Reset values.
`define BANK_CFG_RESET 12'h000
`define DIV_RESET 5'h01
`define IRQ_MASK_RESET 3'h0

// Reference edges with feedback present before lock is declared.
`define LOCK_EDGES 4'h8

`endif

/* design/clock_output_gating_select.v */
// Control logic of a clock generator: input pair selection, lock report,
// post-PLL dividers, synchronous bank gating, output enables and profiles.
// Assumes all control and clock pins are asynchronous to ref_clk, and one
// AHB-Lite master doing single word transfers.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`include "clock_gate_consts.vh"

module clock_output_gating_select
(
  // Clock and reset.
  input wire ref_clk,
  input wire reset,
  // Clock input pairs, positive legs.
  input wire ref_pair_a,
  input wire ref_pair_b,
  input wire fb_pair_a,
  input wire fb_pair_b,
  // Control pins.
  input wire ref_pair_select,
  input wire fb_pair_select,
  input wire sync_gate_in,
  input wire global_hiz_ctl,
  input wire out_enable_x,
  input wire out_enable_y,
  input wire profile_sel_lo,
  input wire profile_sel_hi,
  input wire pll_bypass,
  input wire pll_reset,
  // Clock outputs, two per bank, with active-low output enables.
  output reg [19:0] clk_out,
  output reg [19:0] clk_out_oe_n,
  output reg [29:0] bank_drv_type,
  output reg lock_n,
  // AHB-Lite slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // Interrupt.
  output reg irq
);

  localparam NPIN = 14;

  // Three-stage synchronisers with agreement filter on every pin.
  wire [NPIN-1:0] pin_raw;
  reg [NPIN-1:0] sync1_q;
  reg [NPIN-1:0] sync2_q;
  reg [NPIN-1:0] sync3_q;
  reg [NPIN-1:0] pin_q;
  reg [NPIN-1:0] pin_prev_q;

  assign pin_raw = {pll_reset, pll_bypass, profile_sel_hi, profile_sel_lo,
                    out_enable_y, out_enable_x, global_hiz_ctl, sync_gate_in,
                    fb_pair_select, ref_pair_select, fb_pair_b, fb_pair_a,
                    ref_pair_b, ref_pair_a};

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1)
    begin : gen_sync
      always @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
          pin_prev_q[g] <= 1'b0;
        end
        else
        begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g])
            pin_q[g] <= sync3_q[g];
          pin_prev_q[g] <= pin_q[g];
        end
      end
    end
  endgenerate

  wire ref_a = pin_q[0];
  wire ref_b = pin_q[1];
  wire fb_a = pin_q[2];
  wire fb_b = pin_q[3];
  wire ref_sel = pin_q[4];
  wire fb_sel = pin_q[5];
  wire gate_in = pin_q[6];
  wire hiz = pin_q[7];
  wire oe_x = pin_q[8];
  wire oe_y = pin_q[9];
  wire bypass = pin_q[12];
  wire pll_rst = pin_q[13];

  wire [1:0] prof = pin_q[11:10];
  wire prof_chg = (pin_q[11:10] != pin_prev_q[11:10]);

  wire ref_now = ref_sel ? ref_b : ref_a;
  wire ref_was = ref_sel ? pin_prev_q[1] : pin_prev_q[0];
  wire ref_edge = ref_now & ~ref_was;
  wire fb_now = fb_sel ? fb_b : fb_a;
  wire fb_was = fb_sel ? pin_prev_q[3] : pin_prev_q[2];
  // Feedback buffer off under global high impedance.
  wire fb_edge = fb_now & ~fb_was & ~hiz;

  // Stored profiles: 10 bank words and 5 divider ratios per profile.
  reg [11:0] bank_cfg_q [0:39];
  reg [4:0] div_ratio_q [0:19];

  // Lock detector: counts reference edges that each saw a feedback edge.
  reg fb_seen_q;
  reg [3:0] lock_cnt_q;
  wire locked = (lock_cnt_q == `LOCK_EDGES);

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fb_seen_q <= 1'b0;
      lock_cnt_q <= 4'h0;
    end
    // PLL reset clears lock; high impedance loses lock.
    else if (pll_rst || hiz)
    begin
      fb_seen_q <= 1'b0;
      lock_cnt_q <= 4'h0;
    end
    else
    begin
      if (ref_edge)
      begin
        fb_seen_q <= fb_edge;
        if (!fb_seen_q)
          lock_cnt_q <= 4'h0;
        else if (!locked)
          lock_cnt_q <= lock_cnt_q + 4'h1;
      end
      else if (fb_edge)
        fb_seen_q <= 1'b1;
    end
  end

  // Divider source: VCO every cycle, or the selected reference edge on bypass.
  wire div_tick = bypass ? ref_edge : 1'b1;

  // Five post-PLL dividers; output level toggles every ratio ticks.
  reg [4:0] div_cnt_q [0:4];
  reg [4:0] div_lvl_q;

  generate
    for (g = 0; g < 5; g = g + 1)
    begin : gen_div
      // Ratio taken from the selected profile.
      wire [4:0] ratio = div_ratio_q[{prof, 2'h0} + prof + g];
      wire [4:0] last = (ratio == 5'h00) ? 5'h00 : ratio - 5'h01;
      always @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          div_cnt_q[g] <= 5'h00;
          div_lvl_q[g] <= 1'b0;
        end
        else if (pll_rst)
        begin
          div_cnt_q[g] <= 5'h00;
          div_lvl_q[g] <= 1'b0;
        end
        else if (div_tick)
        begin
          if (div_cnt_q[g] >= last)
          begin
            div_cnt_q[g] <= 5'h00;
            div_lvl_q[g] <= ~div_lvl_q[g];
          end
          else
            div_cnt_q[g] <= div_cnt_q[g] + 5'h01;
        end
      end
    end
  endgenerate

  // Enable source decode, used for both outputs of each bank.
  function en_of;
    input [1:0] src;
    input px;
    input py;
    begin
      case (src)
        `OE_ALWAYS_ON: en_of = 1'b1;
        `OE_ALWAYS_OFF: en_of = 1'b0;
        `OE_PIN_X: en_of = px;
        `OE_PIN_Y: en_of = py;
        default: en_of = 1'b0;
      endcase
    end
  endfunction

  // Bank output stage.
  reg [9:0] run_q;

  generate
    for (g = 0; g < 10; g = g + 1)
    begin : gen_bank
      // Bank word from the selected profile.
      wire [11:0] cfg = bank_cfg_q[{prof, 3'h0} + {prof, 1'b0} + g];
      wire [2:0] dsel = cfg[`BCFG_DIV_LSB +: 3];
      // Divider choice, values above 4 fold onto divider 4.
      wire lvl = (dsel > 3'h4) ? div_lvl_q[4] : div_lvl_q[dsel];
      wire gated = cfg[`BCFG_GATE_BIT];
      wire pass = gated ? run_q[g] : 1'b1;
      wire en_a = en_of(cfg[`BCFG_OEA_LSB +: 2], oe_x, oe_y);
      wire en_b = en_of(cfg[`BCFG_OEB_LSB +: 2], oe_x, oe_y);
      always @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          run_q[g] <= 1'b0;
          clk_out[2*g] <= 1'b0;
          clk_out[2*g+1] <= 1'b0;
          clk_out_oe_n[2*g] <= 1'b1;
          clk_out_oe_n[2*g+1] <= 1'b1;
          bank_drv_type[3*g +: 3] <= 3'h0;
        end
        else
        begin
          // Gate state moves only while the bank clock is low.
          if (!lvl)
            run_q[g] <= gate_in;
          clk_out[2*g] <= lvl & pass;
          clk_out[2*g+1] <= lvl & pass;
          // Global high impedance overrides every enable.
          clk_out_oe_n[2*g] <= hiz | ~en_a;
          clk_out_oe_n[2*g+1] <= hiz | ~en_b;
          bank_drv_type[3*g +: 3] <= cfg[`BCFG_DRV_LSB +: 3];
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      lock_n <= 1'b1;
    else
      lock_n <= ~locked;
  end

  // Interrupt events.
  reg locked_prev_q;
  reg [2:0] irq_st_q;
  reg [2:0] irq_mask_q;
  wire [2:0] irq_set = {prof_chg, locked_prev_q & ~locked, ~locked_prev_q & locked};

  // AHB-Lite slave, zero wait states.
  reg dp_wr_q;
  reg [11:0] dp_addr_q;
  wire ap_valid = hsel & hready & htrans[1];
  wire [11:0] ap_addr = haddr[11:0];
  wire wr_bank = dp_wr_q && dp_addr_q[11:8] == 4'h1 && dp_addr_q[7:2] < 6'd40;
  wire wr_div = dp_wr_q && dp_addr_q[11:8] == 4'h2 && dp_addr_q[7:2] < 6'd20;
  wire [2:0] irq_clr = (dp_wr_q && dp_addr_q == `OFS_IRQ_STATUS) ? hwdata[2:0] : 3'h0;

  reg [31:0] rd_d;
  always @*
  begin
    rd_d = 32'h00000000;
    if (ap_addr == `OFS_STATUS)
      rd_d = {24'h000000, run_q[0], gate_in, hiz, bypass, pll_rst, prof, locked};
    else if (ap_addr == `OFS_IRQ_STATUS)
      rd_d = {29'h00000000, irq_st_q};
    else if (ap_addr == `OFS_IRQ_MASK)
      rd_d = {29'h00000000, irq_mask_q};
    else if (ap_addr[11:8] == 4'h1 && ap_addr[7:2] < 6'd40)
      rd_d = {20'h00000, bank_cfg_q[ap_addr[7:2]]};
    else if (ap_addr[11:8] == 4'h2 && ap_addr[7:2] < 6'd20)
      rd_d = {27'h0000000, div_ratio_q[ap_addr[6:2]]};
  end

  integer i;
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      irq_st_q <= 3'h0;
      irq_mask_q <= `IRQ_MASK_RESET;
      locked_prev_q <= 1'b0;
      irq <= 1'b0;
      for (i = 0; i < 40; i = i + 1)
        bank_cfg_q[i] <= `BANK_CFG_RESET;
      for (i = 0; i < 20; i = i + 1)
        div_ratio_q[i] <= `DIV_RESET;
    end
    else
    begin
      dp_wr_q <= ap_valid & hwrite;
      dp_addr_q <= {ap_addr[11:2], 2'h0};
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_valid && !hwrite)
        hrdata <= rd_d;
      locked_prev_q <= locked;
      // Set wins over a write-one clear in the same cycle.
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
      irq <= |(((irq_st_q & ~irq_clr) | irq_set) & irq_mask_q);
      if (dp_wr_q && dp_addr_q == `OFS_IRQ_MASK)
        irq_mask_q <= hwdata[2:0];
      if (wr_bank)
        bank_cfg_q[dp_addr_q[7:2]] <= {hwdata[11:8], 1'b0, hwdata[6:0]};
      if (wr_div)
        div_ratio_q[dp_addr_q[6:2]] <= hwdata[4:0];
    end
  end

endmodule

/* test/clock_gate_monitor.sv */
// Port checker for the clock output gating and selection block.
// Assumes one ref_clk domain and an active-high reset; bound below.
`timescale 1ns/10ps
module clock_gate_monitor (
  // Clock and reset.
  input wire ref_clk,
  input wire reset,
  // Pins and outputs.
  input wire global_hiz_ctl,
  input wire pll_reset,
  input wire [19:0] clk_out_oe_n,
  input wire lock_n,
  input wire irq,
  // Bus.
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_hiz_oe; global_hiz_ctl [*7] |-> &clk_out_oe_n; endproperty
  a_hiz_oe: assert property (p_hiz_oe)
    else $error("output driven under global hiz");
  property p_hiz_lock; global_hiz_ctl [*8] |-> lock_n; endproperty
  a_hiz_lock: assert property (p_hiz_lock)
    else $error("lock held under global hiz");
  property p_rst_lock; pll_reset [*8] |-> lock_n; endproperty
  a_rst_lock: assert property (p_rst_lock)
    else $error("lock held under pll reset");
  property p_gain_rst; $fell(lock_n) |-> !$past(pll_reset, 8); endproperty
  a_gain_rst: assert property (p_gain_rst)
    else $error("lock gained too soon after pll reset");
  property p_gain_hiz; $fell(lock_n) |-> !$past(global_hiz_ctl, 8); endproperty
  a_gain_hiz: assert property (p_gain_hiz)
    else $error("lock gained too soon after global hiz");
  property p_okay; 1'b1 |-> hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay)
    else $error("bus not ready or error response");
  property p_rdata;
    !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data changed without a read");
  property p_irq_fall;
    $fell(irq) |-> $past(hsel && hready && htrans[1] && hwrite, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
endmodule
bind clock_output_gating_select clock_gate_monitor u_mon (.ref_clk, .reset,
  .global_hiz_ctl, .pll_reset, .clk_out_oe_n, .lock_n, .irq, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata);

/* test/board_clocks.sv */
// Board clock sources feeding the clock output block.
// Assumes ref_clk; pair A sources run, pair B sources are absent.
`timescale 1ns/10ps
module board_clocks (
  // Clock and reset.
  input wire ref_clk,
  input wire reset,
  // Clock pins toward the block.
  output logic ref_pair_a,
  output logic ref_pair_b,
  output logic fb_pair_a,
  output logic fb_pair_b
);
  logic [2:0] cnt_q;
  always @(posedge ref_clk or posedge reset)
    if (reset)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_q + 3'h1;
  // Feedback runs twice as fast, so every reference edge has one before it.
  assign ref_pair_a = cnt_q[2];
  assign fb_pair_a = cnt_q[1];
  // Unplugged pair B inputs sit at the termination level.
  assign ref_pair_b = 1'b0;
  assign fb_pair_b = 1'b0;
endmodule

/* test/tb.sv */
// Self-checking bench for the clock output gating and selection block.
// Assumes a zero-wait AHB-Lite slave and board clocks from board_clocks.
`timescale 1ns/10ps
`include "clock_gate_consts.vh"
module tb;
  logic ref_clk, reset, ref_pair_a, ref_pair_b, fb_pair_a, fb_pair_b;
  logic ref_pair_select, fb_pair_select, sync_gate_in, global_hiz_ctl;
  logic out_enable_x, out_enable_y, profile_sel_lo, profile_sel_hi, pll_bypass, pll_reset;
  logic [19:0] clk_out, clk_out_oe_n;
  logic [29:0] bank_drv_type;
  logic lock_n, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd, n;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_errors, tests_run, cycles;
  board_clocks u_board (.ref_clk, .reset, .ref_pair_a, .ref_pair_b, .fb_pair_a, .fb_pair_b);
  clock_output_gating_select u_dut (.ref_clk, .reset, .ref_pair_a, .ref_pair_b,
    .fb_pair_a, .fb_pair_b, .ref_pair_select, .fb_pair_select, .sync_gate_in,
    .global_hiz_ctl, .out_enable_x, .out_enable_y, .profile_sel_lo, .profile_sel_hi,
    .pll_bypass, .pll_reset, .clk_out, .clk_out_oe_n, .bank_drv_type, .lock_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .irq);
  task stop_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1; hwrite <= wr; haddr <= {20'h00000, a}; htrans <= 2'h2; hsize <= 3'h2;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task highs(input int idx);
    n = 32'h0;
    repeat (20) @(negedge ref_clk) n = n + clk_out[idx];
  endtask
  task t_lock_irq;
    cyc(100); check("lock", lock_n, 0);
    check("irq masked", irq, 0);
    bus(0, `OFS_IRQ_STATUS, 0); check("lock event", rd[0], 1);
    bus(1, `OFS_IRQ_MASK, 1); cyc(2); check("irq", irq, 1);
    bus(1, `OFS_IRQ_STATUS, 1); cyc(2); check("irq clr", irq, 0);
    bus(0, `OFS_STATUS, 0); check("status lock", rd[0], 1);
    bus(0, 12'h300, 32'h0); check("unmapped", rd, 0);
    fb_pair_select <= 1; cyc(100); check("fb b", lock_n, 1);
    fb_pair_select <= 0; cyc(100); check("fb a", lock_n, 0);
    ref_pair_select <= 1; pll_reset <= 1; cyc(10); check("pll rst", lock_n, 1);
    pll_reset <= 0; cyc(100); check("ref b", lock_n, 1);
    ref_pair_select <= 0; cyc(100); check("ref a", lock_n, 0);
    global_hiz_ctl <= 1; cyc(10); check("hiz lock", lock_n, 1);
    check("hiz oe", clk_out_oe_n, 20'hFFFFF);
    global_hiz_ctl <= 0; cyc(10);
  endtask
  task t_enables;
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 4; s++)
      begin
        out_enable_x <= (p == 0); out_enable_y <= (p == 1);
        bus(1, `OFS_BANK_BASE, {22'h0, s[1:0], 8'h28}); cyc(8);
        check("bank word", clk_out_oe_n[0], !(s == 0 || s == 2 + p));
      end
    check("drv type", bank_drv_type[2:0], 5);
  endtask
  task t_gate;
    bus(1, `OFS_BANK_BASE, 32'h40); bus(1, 12'h104, 32'h0);
    sync_gate_in <= 0; cyc(8);
    highs(0); check("gated", n, 0);
    highs(2); check("ungated", n, 10);
    sync_gate_in <= 1; cyc(8);
    highs(0); check("gate open", n, 10);
  endtask
  task t_bypass;
    bus(1, 12'h228, 32'h7); bus(0, 12'h228, 0); check("div ratio", rd, 7);
    pll_bypass <= 1; cyc(24); n = 32'h0;
    @(negedge ref_clk) rd[0] = clk_out[2];
    repeat (16) @(negedge ref_clk)
    begin
      n = n + (clk_out[2] ^ rd[0]);
      rd[0] = clk_out[2];
    end
    check("bypass toggles", n, 2);
    pll_bypass <= 0; cyc(8);
  endtask
  task t_profile;
    bus(1, 12'h150, 32'h100);
    profile_sel_hi <= 1; cyc(8); check("profile 2", clk_out_oe_n[0], 1);
    profile_sel_hi <= 0; profile_sel_lo <= 1; cyc(8);
    check("profile 1", clk_out_oe_n[0], 0);
  endtask
  initial
  begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      stop_test;
    end
  end
  initial
  begin
    {reset, ref_pair_select, fb_pair_select, sync_gate_in, global_hiz_ctl} = 5'h10;
    {out_enable_x, out_enable_y, profile_sel_lo, profile_sel_hi, pll_bypass, pll_reset} = 0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = 0;
    cyc(16);
    check("rst lock", lock_n, 1);
    check("rst oe", clk_out_oe_n, 20'hFFFFF);
    reset <= 0;
    cyc(1);
    t_lock_irq;
    t_enables;
    t_gate;
    t_bypass;
    t_profile;
    stop_test;
  end
endmodule
